// File: burst_counter.sv
`timescale 1ns/1ps
module burst_counter
    import sram_port_pkg::*;
(
    input wire logic clk_i,                  // Clock.
    input wire logic rst_i,                  // Synchronous reset.
    input wire logic load_i,                 // Load a start address.
    input wire logic [BURST_W-1:0] start_i,  // Start address low bits.
    input wire logic step_i,                 // Advance one step.
    input wire burst_order_t order_i,        // Burst order.
    output logic [BURST_W-1:0] addr_o        // Low bits of this access.
);

    typedef struct packed {
        logic [BURST_W-1:0] start;
        logic [BURST_W-1:0] idx;
    } cnt_regs_t;

    cnt_regs_t q;
    cnt_regs_t d;

    always_comb begin
        d = q;
        if (load_i) begin
            d.start = start_i;
            d.idx = BURST_IDX_RST;
        end else if (step_i) begin
            d.idx = BURST_W'(q.idx + BURST_ONE);
        end
        if (order_i == ORDER_INTERLEAVED) begin
            addr_o = d.start ^ d.idx;
        end else begin
            addr_o = BURST_W'(d.start + d.idx);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// File: burst_sram_port.sv
`timescale 1ns/1ps
module burst_sram_port
    import sram_port_pkg::*;
(
    input wire logic clk_i,                            // Clock.
    input wire logic rst_i,                            // Sync reset.
    input wire logic [ADDR_W-1:0] addr_i,              // Address.
    input wire logic processor_addr_strobe_n_i,        // Processor strobe.
    input wire logic controller_addr_strobe_n_i,       // Controller strobe.
    input wire logic burst_step_n_i,                   // Burst advance.
    input wire logic global_write_n_i,                 // Write all lanes.
    input wire logic byte_write_enable_n_i,            // Byte write enable.
    input wire logic [LANES-1:0] byte_write_select_n_i, // Lane selects.
    input wire logic chip_sel1_n_i,                    // Chip select 1.
    input wire logic chip_sel2_i,                      // Chip select 2.
    input wire logic chip_sel3_n_i,                    // Chip select 3.
    input wire logic output_drive_en_n_i,              // Async drive enable.
    input wire logic sleep_request_i,                  // Async sleep.
    input wire logic burst_order_i,                    // Order strap.
    input wire logic [DATA_W-1:0] data_i,              // Data pin input.
    output logic [DATA_W-1:0] data_o,                  // Data pin output.
    output logic data_oe_o,                            // Data pin enable.
    output logic sleep_o                               // Device asleep.
);

    // ****************************************************************
    // Decoding helpers.
    // ****************************************************************
    function automatic logic all_selected(input bus_in_t s);
        return !s.sel1_n && s.sel2 && !s.sel3_n;
    endfunction

    // An internal write is any global write, or a byte write with at
    // least one lane chosen.
    function automatic logic write_request(input bus_in_t s);
        return !s.global_write_n ||
               (!s.byte_write_n && (s.lane_sel_n != '1));
    endfunction

    function automatic logic [LANES-1:0] lane_mask(input bus_in_t s);
        logic [LANES-1:0] m;
        m = '0;
        if (!s.global_write_n) begin
            m = '1;
        end else if (!s.byte_write_n) begin
            m = ~s.lane_sel_n;
        end
        return m;
    endfunction

    // ****************************************************************
    // Asynchronous inputs.
    // ****************************************************************
    // The strap is synchronised as well, so a stray change cannot
    // upset the counter in mid-cycle; it is still meant to stay put.
    logic [2:0] async_raw;
    logic [2:0] async_sync;
    logic sleep_s;
    logic drive_en_n_s;
    burst_order_t order_s;

    assign async_raw = {sleep_request_i, output_drive_en_n_i,
                        burst_order_i};

    sync_stages #(
        .WIDTH(3),
        .RST_VAL({SLEEP_RST, DRIVE_EN_N_RST, ORDER_RST})
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(async_raw),
        .sync_o(async_sync)
    );

    // The two synchroniser stages and the state register make the sleep delay.
    assign sleep_s = async_sync[2];
    assign drive_en_n_s = async_sync[1];
    assign order_s = burst_order_t'(async_sync[0]);

    // ****************************************************************
    // State and storage.
    // ****************************************************************
    port_regs_t q;
    port_regs_t d;
    logic [DATA_W-1:0] mem [DEPTH];

    logic load;
    logic step;
    logic do_write;
    logic do_read;
    logic [LANES-1:0] lanes;
    logic [BURST_W-1:0] low_addr;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:BURST_W] acc_upper;
    logic proc_seen;
    logic ctrl_seen;

    burst_counter u_burst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load),
        .start_i(q.in.addr[BURST_W-1:0]),
        .step_i(step),
        .order_i(order_s),
        .addr_o(low_addr)
    );

    assign acc_upper = load ? q.in.addr[ADDR_W-1:BURST_W] : q.upper;
    assign acc_addr = {acc_upper, low_addr};

    // ****************************************************************
    // Access decode on the registered pin sample.
    // ****************************************************************
    always_comb begin
        d = q;
        load = 1'b0;
        step = 1'b0;
        do_write = 1'b0;
        do_read = 1'b0;
        lanes = '0;
        // Every synchronous pin is sampled into the input register.
        d.in.addr = addr_i;
        d.in.proc_strobe_n = processor_addr_strobe_n_i;
        d.in.ctrl_strobe_n = controller_addr_strobe_n_i;
        d.in.step_n = burst_step_n_i;
        d.in.global_write_n = global_write_n_i;
        d.in.byte_write_n = byte_write_enable_n_i;
        d.in.lane_sel_n = byte_write_select_n_i;
        d.in.sel1_n = chip_sel1_n_i;
        d.in.sel2 = chip_sel2_i;
        d.in.sel3_n = chip_sel3_n_i;
        d.in.data = data_i;
        // The processor strobe counts only while select 1 is low and
        // wins over the controller strobe.
        proc_seen = !q.in.proc_strobe_n && !q.in.sel1_n;
        ctrl_seen = !proc_seen && !q.in.ctrl_strobe_n;
        unique case (q.state)
            ST_SLEEP: begin
                d.drive = 1'b0;
                if (!sleep_s) begin
                    d.state = ST_IDLE;
                end
            end
            ST_IDLE,
            ST_BURST: begin
                if (sleep_s) begin
                    // Whatever was pending is simply dropped.
                    d.state = ST_SLEEP;
                    d.drive = 1'b0;
                end else if (proc_seen) begin
                    if (all_selected(q.in)) begin
                        // First cycle is always a read.
                        load = 1'b1;
                        do_read = 1'b1;
                    end
                end else if (ctrl_seen) begin
                    if (all_selected(q.in)) begin
                        load = 1'b1;
                        do_write = write_request(q.in);
                        do_read = !do_write;
                    end
                end else if (q.state == ST_BURST) begin
                    step = !q.in.step_n;
                    do_write = write_request(q.in);
                    do_read = !do_write;
                end
                if (load) begin
                    d.state = ST_BURST;
                    d.upper = q.in.addr[ADDR_W-1:BURST_W];
                end else if ((proc_seen || ctrl_seen) && !sleep_s) begin
                    d.state = ST_IDLE;
                end
                if (do_write) begin
                    lanes = lane_mask(q.in);
                    d.drive = 1'b0;
                end else if (do_read) begin
                    d.dout = mem[acc_addr];
                    // Leaving deselect masks the first cycle.
                    d.drive = (q.state == ST_BURST);
                end else begin
                    d.drive = 1'b0;
                end
            end
            default: begin
                d.state = ST_IDLE;
                d.drive = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.state <= ST_IDLE;
            q.in <= '0;
            q.in.proc_strobe_n <= STROBE_IDLE_N;
            q.in.ctrl_strobe_n <= STROBE_IDLE_N;
            q.in.step_n <= 1'b1;
            q.in.global_write_n <= 1'b1;
            q.in.byte_write_n <= 1'b1;
            q.in.lane_sel_n <= '1;
            q.in.sel1_n <= 1'b1;
            q.upper <= '0;
            q.dout <= '0;
            q.drive <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Storage has no reset, so contents survive sleep and reset.
    // Only the chosen lanes change; one process owns the whole array.
    always_ff @(posedge clk_i) begin
        for (int g = 0; g < LANES; g++) begin
            if (lanes[g]) begin
                mem[acc_addr][g*BYTE_W +: BYTE_W] <=
                    q.in.data[g*BYTE_W +: BYTE_W];
            end
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign data_o = q.dout;
    // A write seen in this cycle drops the drivers at once.
    assign data_oe_o = q.drive && !drive_en_n_s && !do_write &&
                       (q.state != ST_SLEEP);
    assign sleep_o = (q.state == ST_SLEEP);

endmodule

// File: burst_sram_port_sva.sv
`timescale 1ns/1ps
module burst_sram_port_chk
    import sram_port_pkg::*;
(
    input wire logic clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic processor_addr_strobe_n_i, // Pin.
    input wire logic controller_addr_strobe_n_i, // Pin.
    input wire logic burst_step_n_i, // Pin.
    input wire logic global_write_n_i, // Pin.
    input wire logic byte_write_enable_n_i, // Pin.
    input wire logic [LANES-1:0] byte_write_select_n_i, // Pin.
    input wire logic chip_sel1_n_i, // Pin.
    input wire logic chip_sel2_i, // Pin.
    input wire logic chip_sel3_n_i, // Pin.
    input wire logic output_drive_en_n_i, // Pin.
    input wire logic sleep_request_i, // Pin.
    input wire logic [DATA_W-1:0] data_o, // Read data.
    input wire logic data_oe_o, // Drive enable.
    input wire logic sleep_o // Asleep.
);
    // ****************************************************************
    // Port timing checks.
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic sel_on;
    logic strobes_off;
    assign sel_on = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;
    assign strobes_off = processor_addr_strobe_n_i
        && controller_addr_strobe_n_i;
    sequence s_deselect;
        !controller_addr_strobe_n_i && chip_sel1_n_i;
    endsequence
    sequence s_proc_start;
        !processor_addr_strobe_n_i && sel_on;
    endsequence
    sequence s_sleep_on;
        $rose(sleep_request_i) ##1 sleep_request_i [*3];
    endsequence
    sequence s_sleep_off;
        $fell(sleep_request_i) ##1 !sleep_request_i [*4];
    endsequence
    property p_reset;
        $fell(rst_i) |-> !data_oe_o && !sleep_o && data_o == '0;
    endproperty
    property p_ctrl_write;
        !controller_addr_strobe_n_i && processor_addr_strobe_n_i && sel_on
        && (!global_write_n_i || (!byte_write_enable_n_i
        && byte_write_select_n_i != 4'hf)) |=> !data_oe_o;
    endproperty
    property p_cont_write;
        strobes_off && !global_write_n_i |=> !data_oe_o;
    endproperty
    property p_first;
        s_deselect ##1 s_proc_start |-> ##2 !data_oe_o;
    endproperty
    property p_deselect;
        s_deselect |-> ##2 !data_oe_o;
    endproperty
    property p_oe_off;
        output_drive_en_n_i [*4] |-> !data_oe_o;
    endproperty
    property p_sleep_enter;
        s_sleep_on |-> sleep_o && !$past(sleep_o, 2);
    endproperty
    property p_sleep_exit;
        s_sleep_off |-> !sleep_o;
    endproperty
    property p_sleep_quiet;
        sleep_o |-> !data_oe_o;
    endproperty
    property p_hold;
        (strobes_off && global_write_n_i && byte_write_enable_n_i
        && burst_step_n_i) [*5] |-> $stable(data_o);
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not at reset level");
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("driving during a controller write");
    a_cont_write: assert property (p_cont_write)
        else $error("driving during a burst write");
    a_first: assert property (p_first)
        else $error("first access out of deselect driven");
    a_deselect: assert property (p_deselect)
        else $error("driving after deselect");
    a_oe_off: assert property (p_oe_off)
        else $error("driving with drive enable high");
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep entry not two cycles");
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("sleep exit late");
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("driving while asleep");
    a_hold: assert property (p_hold)
        else $error("read data moved without access");
endmodule

bind burst_sram_port burst_sram_port_chk burst_sram_port_chk_i (.*);

// File: burst_sram_port_tb_top.sv
`timescale 1ns/1ps
module burst_sram_port_tb_top import sram_port_pkg::*;;
    // ****************************************************************
    // Stimulus and checking.
    // ****************************************************************
    localparam logic [4:0] IDLE = 5'h1f, DESEL = 5'h17, PRD = 5'h0f;
    localparam logic [4:0] CGW = 5'h15, CBW = 5'h16, STEP = 5'h1b;
    localparam logic [4:0] STEPW = 5'h19, GWR = 5'h1d, BOTH = 5'h05;
    localparam logic [4:0] PGW = 5'h0d;
    typedef struct {int cyc; logic [DATA_W-1:0] val;} note_t;
    logic clk_i = 0, rst_i = 1, oe_n = 1, sleep_req = 0, order = 1;
    logic wr_en = 0, data_oe_o, sleep_o;
    logic [DATA_W-1:0] wr_data = '0, data_i, data_o;
    logic [DATA_W-1:0] ref_mem [int];
    logic [31:0] seed = 32'he588;
    bus_in_t pins = '0;
    note_t notes[$];
    int fails = 0, checks = 0, cyc = 0;
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    burst_sram_port burst_sram_port_i (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(pins.addr),
        .processor_addr_strobe_n_i(pins.proc_strobe_n),
        .controller_addr_strobe_n_i(pins.ctrl_strobe_n),
        .burst_step_n_i(pins.step_n), .global_write_n_i(pins.global_write_n),
        .byte_write_enable_n_i(pins.byte_write_n),
        .byte_write_select_n_i(pins.lane_sel_n),
        .chip_sel1_n_i(pins.sel1_n), .chip_sel2_i(pins.sel2),
        .chip_sel3_n_i(pins.sel3_n), .output_drive_en_n_i(oe_n),
        .sleep_request_i(sleep_req), .burst_order_i(order), .data_i(data_i),
        .data_o(data_o), .data_oe_o(data_oe_o), .sleep_o(sleep_o));
    bus_data_driver bus_data_driver_i (.clk_i(clk_i), .wr_en_i(wr_en),
        .wr_data_i(wr_data), .dev_oe_i(data_oe_o), .dev_data_i(data_o),
        .data_o(data_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic bus_in_t mk(input logic [ADDR_W-1:0] a,
        input logic [4:0] c, input logic [LANES-1:0] ln, input logic s);
        mk = '0;
        mk.addr = a;
        {mk.proc_strobe_n, mk.ctrl_strobe_n, mk.step_n} = c[4:2];
        {mk.global_write_n, mk.byte_write_n, mk.lane_sel_n} = {c[1:0], ln};
        {mk.sel1_n, mk.sel2, mk.sel3_n} = {~s, s, ~s};
    endfunction
    function automatic logic [1:0] seq(input logic [1:0] s, i, input logic o);
        return o ? s ^ i : s + i;
    endfunction
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic put(input bus_in_t p, input logic w,
        input logic [DATA_W-1:0] d, input logic rd, input int ra);
        @(negedge clk_i);
        pins = p;
        wr_en = w;
        wr_data = d;
        if (rd) notes.push_back('{cyc + 2, ref_mem[ra]});
    endtask
    task automatic idle(input int n);
        repeat (n) put(mk(ADDR_W'(rnd()), IDLE, 4'hf, 0), 0, '0, 0, 0);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, k, input logic [4:0] c,
        input logic [LANES-1:0] ln, input logic upd);
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] m;
        d = DATA_W'({rnd(), rnd()});
        m = ref_mem[k];
        for (int g = 0; g < LANES; g++) begin
            if (!c[1] || !ln[g]) m[g*BYTE_W +: BYTE_W] = d[g*BYTE_W +: BYTE_W];
        end
        if (upd) ref_mem[k] = m;
        put(mk(a, c, ln, 1), 1, d, 0, 0);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        put(mk(a, DESEL, 4'hf, 0), 0, '0, 0, 0);
        put(mk(a, PRD, 4'hf, 1), 0, '0, 1, a);
    endtask
    task automatic burst(input logic o);
        logic [ADDR_W-1:0] b;
        b = ADDR_W'(rnd());
        order = o;
        oe_n = 1;
        idle(4);
        for (int i = 0; i < 4; i++) begin
            wr(b, {b[9:2], seq(b[1:0], 2'(i), o)}, i ? STEPW : CGW, 4'h0, 1);
        end
        oe_n = 0;
        idle(3);
        put(mk(b, DESEL, 4'hf, 0), 0, '0, 0, 0);
        for (int i = 0; i < 5; i++) begin
            put(mk(b, i == 0 ? PRD : (i < 4 ? STEP : IDLE), 4'hf, 1), 0, '0,
                1, {b[9:2], seq(b[1:0], 2'(i < 4 ? i : 3), o)});
            if (i == 2) chk("data_oe_o", '0, DATA_W'(data_oe_o));
            if (i == 3) chk("data_oe_o", 1, DATA_W'(data_oe_o));
        end
        idle(6);
    endtask
    always @(negedge clk_i) begin
        if (notes.size() > 0 && notes[0].cyc == cyc) begin
            chk("data_o", notes[0].val, data_o);
            void'(notes.pop_front());
        end
    end
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        logic [ADDR_W-1:0] a;
        int n;
        pins = mk('0, IDLE, 4'hf, 0);
        repeat (12) @(negedge clk_i);
        rst_i = 0;
        chk("flags", '0, DATA_W'({data_oe_o, sleep_o}));
        burst(0);
        burst(1);
        for (int i = 0; i < 3; i++) begin
            a = ADDR_W'(rnd());
            oe_n = 1;
            idle(3);
            wr(a, a, CGW, 4'(rnd()), 1);
            wr(a, a, CBW, 4'(rnd()), 1);
            wr(a, a, BOTH, 4'h0, 0);
            idle(1);
            wr(a ^ 10'h1, a, PGW, 4'h0, 0);
            wr(a, a ^ 10'h1, GWR, 4'hf, 1);
            oe_n = 0;
            idle(3);
            rd(a);
            rd(a ^ 10'h1);
            idle(2);
        end
        sleep_req = 1;
        for (n = 0; n < 8 && sleep_o !== 1'b1; n++) @(negedge clk_i);
        chk("sleep_o", 1, DATA_W'(sleep_o));
        repeat (4) @(negedge clk_i);
        sleep_req = 0;
        for (n = 0; n < 8 && sleep_o !== 1'b0; n++) @(negedge clk_i);
        chk("sleep_o", 0, DATA_W'(sleep_o));
        idle(4);
        rd(a);
        for (n = 0; n < 10 && notes.size() > 0; n++) @(negedge clk_i);
        if (notes.size() > 0) fails++;
        test_done();
    end
endmodule

// File: bus_data_driver.sv
`timescale 1ns/1ps
module bus_data_driver
    import sram_port_pkg::*;
(
    input wire logic clk_i, // Clock.
    input wire logic wr_en_i, // Master drives data.
    input wire logic [DATA_W-1:0] wr_data_i, // Master data.
    input wire logic dev_oe_i, // Device drives data.
    input wire logic [DATA_W-1:0] dev_data_i, // Device data.
    output logic [DATA_W-1:0] data_o // Level on the lines.
);
    // ****************************************************************
    // Shared data lines.
    // ****************************************************************
    logic [DATA_W-1:0] filler_q = '0;
    // Undriven lines toggle every cycle so stale data never looks valid.
    always_ff @(posedge clk_i) begin
        filler_q <= ~data_o;
    end
    assign data_o = wr_en_i ? wr_data_i : (dev_oe_i ? dev_data_i : filler_q);
endmodule

// File: sram_port_pkg.sv
package sram_port_pkg;

    // ****************************************************************
    // Geometry of the array and the word.
    // ****************************************************************
    localparam int ADDR_W = 10;
    localparam int BYTE_W = 9;
    localparam int LANES = 4;
    localparam int DATA_W = BYTE_W * LANES;
    localparam int BURST_W = 2;
    localparam int DEPTH = 1 << ADDR_W;

    // ****************************************************************
    // Timing counts.
    // ****************************************************************
    // Sleep entry and exit take two clock cycles; the synchroniser on
    // the sleep input and the state register together give this delay.
    localparam int SLEEP_ENTRY_CYC = 2;
    localparam int SLEEP_EXIT_CYC = 2;

    // ****************************************************************
    // Reset values and the burst step.
    // ****************************************************************
    localparam logic [BURST_W-1:0] BURST_IDX_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    localparam logic STROBE_IDLE_N = 1'b1;
    localparam logic ORDER_RST = 1'b1;
    localparam logic DRIVE_EN_N_RST = 1'b1;
    localparam logic SLEEP_RST = 1'b0;

    typedef enum logic {
        ORDER_LINEAR,
        ORDER_INTERLEAVED
    } burst_order_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BURST,
        ST_SLEEP
    } port_state_t;

    // One sample of every synchronous input pin.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic proc_strobe_n;
        logic ctrl_strobe_n;
        logic step_n;
        logic global_write_n;
        logic byte_write_n;
        logic [LANES-1:0] lane_sel_n;
        logic sel1_n;
        logic sel2;
        logic sel3_n;
        logic [DATA_W-1:0] data;
    } bus_in_t;

    typedef struct packed {
        port_state_t state;
        bus_in_t in;
        logic [ADDR_W-1:BURST_W] upper;
        logic [DATA_W-1:0] dout;
        logic drive;
    } port_regs_t;

endpackage

// File: sync_stages.sv
`timescale 1ns/1ps
module sync_stages
    import sram_port_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,              // Clock.
    input wire logic rst_i,              // Synchronous reset.
    input wire logic [WIDTH-1:0] async_i, // Asynchronous levels.
    output logic [WIDTH-1:0] sync_o      // Levels in the clock domain.
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_regs_t;

    sync_regs_t q;
    sync_regs_t d;

    always_comb begin
        d = q;
        d.first = async_i;
        d.second = q.first;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= {RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.second;

endmodule
